// [core/wave_stage.sv]
// four-output complementary waveform generator top
`timescale 1ns/100ps
`include "wave_map.svh"
module wave_stage
	import wave_pkg::*;
#(
	parameter int SRC_N     = `WAVE_SRC_COUNT,
	parameter int DEAD_BAND = `WAVE_DEAD_BAND_CYCLES
) (
	input  wire logic                        clk_sys_in,
	input  wire logic                        clk_fast_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        ce_in,
	input  wire logic                        clock_select_in,
	input  wire logic                        enable_in,
	input  wire logic [2:0]                  mode_in,
	input  wire logic [`WAVE_SRC_SEL_W-1:0]  input_source_mux_select_in,
	input  wire logic [SRC_N-1:0]            src_in,
	input  wire logic [3:0]                  per_output_level_sense_in,
	input  wire logic [3:0]                  steer_enable_in,
	input  wire logic                        shutdown_in,
	input  wire logic [3:0]                  override_en_in,
	input  wire logic [3:0]                  override_level_in,
	output logic                             wave_out_a,
	output logic                             wave_out_b,
	output logic                             wave_out_c,
	output logic                             wave_out_d,
	output logic                             clock_is_fast_out
);
	// module clock picked by one bit; glitch-free clock muxing is left to
	// the clock tree, so here both clocks must be the same edge domain
	logic clk_mod;
	assign clk_mod = clock_select_in ? clk_fast_in : clk_sys_in;

	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge clk_mod or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// sources come from other blocks and pins, so resynchronise them
	logic [SRC_N-1:0] src_sync;
	wave_sync2 #(
		.W(SRC_N)
	) u_sync (
		.clk_in   (clk_mod),
		.rst_n_in (rst_sync_q),
		.ce_in    (ce_in),
		.d_in     (src_in),
		.q_out    (src_sync)
	);

	logic data_in;
	wave_src_mux #(
		.SRC_N(SRC_N)
	) u_mux (
		.src_in  (src_sync),
		.sel_in  (input_source_mux_select_in),
		.src_out (data_in)
	);

	logic data_q;
	logic rise;
	always_ff @(posedge clk_mod or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			data_q <= 1'b0;
		end else if (ce_in) begin
			data_q <= data_in;
		end
	end
	assign rise = data_in & ~data_q;

	logic is_bridge;
	logic is_pp;
	logic is_sync_steer;
	assign is_bridge     = (mode_in[2:1] == `WAVE_MODE_BRIDGE_FWD >> 1) && !mode_in[2];
	assign is_pp         = (mode_in == `WAVE_MODE_PUSH_PULL);
	assign is_sync_steer = (mode_in == `WAVE_MODE_SYNC_STEER);

	// push-pull sequencer: 0 means next pulse to a
	logic pp_sel_q;
	logic pp_cur_q;
	always_ff @(posedge clk_mod or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pp_sel_q <= 1'b0;
			pp_cur_q <= 1'b0;
		end else if (ce_in) begin
			// held at start while off or shut down
			if (!enable_in || shutdown_in || !is_pp) begin
				pp_sel_q <= 1'b0;
				pp_cur_q <= 1'b0;
			end else if (rise) begin
				pp_cur_q <= pp_sel_q;
				pp_sel_q <= ~pp_sel_q;
			end
		end
	end

	// steering selection latch
	logic [3:0] steer_q;
	always_ff @(posedge clk_mod or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			steer_q <= 4'h0;
		end else if (ce_in) begin
			if (!is_sync_steer || rise) begin
				steer_q <= steer_enable_in;
			end
		end
	end

	logic [3:0] steer_now;
	assign steer_now = (!is_sync_steer || rise) ? steer_enable_in : steer_q;

	// bridge direction with dead band on reversal
	bridge_state_type br_q;
	logic             dir_q;
	logic [`WAVE_DEAD_CNT_W-1:0] dead_q;
	always_ff @(posedge clk_mod or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			br_q   <= BR_IDLE;
			dir_q  <= 1'b0;
			dead_q <= '0;
		end else if (ce_in) begin
			case (br_q)
				BR_IDLE: begin
					if (enable_in && is_bridge) begin
						dir_q <= mode_in[0];
						br_q  <= BR_RUN;
					end
				end
				BR_RUN: begin
					if (!enable_in || !is_bridge) begin
						br_q <= BR_IDLE;
					end else if (mode_in[0] != dir_q) begin
						dir_q  <= mode_in[0];
						dead_q <= DEAD_BAND[`WAVE_DEAD_CNT_W-1:0] - 1'b1;
						br_q   <= BR_DEAD;
					end
				end
				BR_DEAD: begin
					if (!enable_in || !is_bridge) begin
						br_q <= BR_IDLE;
					end else if (mode_in[0] != dir_q) begin
						dir_q  <= mode_in[0];
						dead_q <= DEAD_BAND[`WAVE_DEAD_CNT_W-1:0] - 1'b1;
					end else if (dead_q == '0) begin
						br_q <= BR_RUN;
					end else begin
						dead_q <= dead_q - 1'b1;
					end
				end
				default: begin
					br_q <= BR_IDLE;
				end
			endcase
		end
	end

	// active-sense levels before polarity
	logic [3:0] act;
	always_comb begin
		act = 4'h0;
		if (enable_in && !shutdown_in) begin
			case (mode_in)
				`WAVE_MODE_SYNC_STEER, `WAVE_MODE_ASYNC_STEER: begin
					act = steer_now & {4{data_in}};
				end
				`WAVE_MODE_PUSH_PULL: begin
					// alternate a and b; owner fixed at the rising edge
					// so no first-cycle sliver leaks to the other output
					act[0] = data_in & (rise ? ~pp_sel_q : (~pp_cur_q & pp_sel_q));
					act[1] = data_in & (rise ? pp_sel_q : (pp_cur_q & ~pp_sel_q));
					// c and d mirror a and b
					act[2] = act[0];
					act[3] = act[1];
				end
				`WAVE_MODE_BRIDGE_FWD, `WAVE_MODE_BRIDGE_REV: begin
					if (br_q == BR_RUN && !dir_q) begin
						act = {data_in, 1'b0, 1'b0, 1'b1};
					end else if (br_q == BR_RUN) begin
						act = {1'b0, 1'b1, data_in, 1'b0};
					end
				end
				default: begin
					act = 4'h0;
				end
			endcase
		end
	end

	// polarity, then override which bypasses it
	logic [3:0] pin_d;
	logic [3:0] pin_q;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_out
			assign pin_d[gi] = override_en_in[gi] ? override_level_in[gi]
				: (per_output_level_sense_in[gi] ? act[gi] : ~act[gi]);
		end
	endgenerate

	always_ff @(posedge clk_mod or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pin_q <= 4'h0;
		end else if (ce_in) begin
			pin_q <= pin_d;
		end
	end
	assign wave_out_a = pin_q[0];
	assign wave_out_b = pin_q[1];
	assign wave_out_c = pin_q[2];
	assign wave_out_d = pin_q[3];

	always_ff @(posedge clk_mod or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			clock_is_fast_out <= 1'b0;
		end else if (ce_in) begin
			clock_is_fast_out <= clock_select_in;
		end
	end

	// no bridge drive during dead band
	property p_dead_quiet;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		(br_q == BR_DEAD) && ce_in && is_bridge |-> act == 4'h0;
	endproperty
	a_dead_quiet: assert property (p_dead_quiet) else $error("drive during dead band");

	// sequencer reset while disabled or shut down
	property p_pp_reset;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		ce_in && (!enable_in || shutdown_in) |=> !pp_sel_q && !pp_cur_q;
	endproperty
	a_pp_reset: assert property (p_pp_reset) else $error("sequencer not reset");

	property p_pp_adv;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		ce_in && enable_in && !shutdown_in && is_pp && rise |=> pp_sel_q != $past(pp_sel_q);
	endproperty
	a_pp_adv: assert property (p_pp_adv) else $error("sequencer did not advance");

	// c and d mirror a and b, each with its own sense
	property p_pp_mirror;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		ce_in && is_pp && override_en_in == 4'h0
		|=> ((wave_out_c ^ $past(per_output_level_sense_in[2]))
			== (wave_out_a ^ $past(per_output_level_sense_in[0])))
			&& ((wave_out_d ^ $past(per_output_level_sense_in[3]))
			== (wave_out_b ^ $past(per_output_level_sense_in[1])));
	endproperty
	a_pp_mirror: assert property (p_pp_mirror) else $error("c/d not mirroring");

	property p_fwd;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		enable_in && !shutdown_in && is_bridge && br_q == BR_RUN && !dir_q
		|-> act[0] && !act[1] && !act[2];
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward levels wrong");

	property p_rev;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		enable_in && !shutdown_in && is_bridge && br_q == BR_RUN && dir_q
		|-> act[2] && !act[0] && !act[3];
	endproperty
	a_rev: assert property (p_rev) else $error("reverse levels wrong");

	// async steering takes effect next cycle
	property p_async_steer;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		ce_in && mode_in == `WAVE_MODE_ASYNC_STEER |=> steer_q == $past(steer_enable_in);
	endproperty
	a_async_steer: assert property (p_async_steer) else $error("steer late");

	// sync steering holds without a rising edge
	property p_sync_steer;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		ce_in && is_sync_steer && !rise |=> $stable(steer_q);
	endproperty
	a_sync_steer: assert property (p_sync_steer) else $error("steer changed early");

	property p_override;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		ce_in && override_en_in[0] |=> wave_out_a == $past(override_level_in[0]);
	endproperty
	a_override: assert property (p_override) else $error("override altered");

	// reversal enters a full dead band
	sequence s_dir_flip;
		ce_in && enable_in && is_bridge && br_q == BR_RUN && mode_in[0] != dir_q;
	endsequence
	sequence s_dead_entered;
		br_q == BR_DEAD && dead_q == DEAD_BAND[`WAVE_DEAD_CNT_W-1:0] - 1'b1
		&& dir_q == $past(mode_in[0]);
	endsequence
	property p_dead_enter;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		s_dir_flip |=> s_dead_entered;
	endproperty
	a_dead_enter: assert property (p_dead_enter) else $error("no dead band on reversal");

	// dead band ends into new drive
	sequence s_dead_over;
		ce_in && enable_in && is_bridge && br_q == BR_DEAD && dead_q == '0 && mode_in[0] == dir_q;
	endsequence
	property p_dead_done;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		s_dead_over |=> br_q == BR_RUN;
	endproperty
	a_dead_done: assert property (p_dead_done) else $error("dead band did not end");

	property p_shutdown_quiet;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		shutdown_in |-> act == 4'h0;
	endproperty
	a_shutdown_quiet: assert property (p_shutdown_quiet) else $error("drive in shutdown");

	property p_bad_mode;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		mode_in > `WAVE_MODE_PUSH_PULL |-> act == 4'h0;
	endproperty
	a_bad_mode: assert property (p_bad_mode) else $error("drive in unused mode");

	property p_pp_owner;
		@(posedge clk_mod) disable iff (!rst_sync_q)
		enable_in && !shutdown_in && is_pp && rise
		|-> act[0] == !pp_sel_q && act[1] == pp_sel_q;
	endproperty
	a_pp_owner: assert property (p_pp_owner) else $error("pulse on wrong output");
endmodule

// [include/wave_map.svh]
// constants for the complementary waveform output stage
`ifndef WAVE_MAP_SVH
`define WAVE_MAP_SVH
`define WAVE_MODE_SYNC_STEER   3'h0
`define WAVE_MODE_ASYNC_STEER  3'h1
`define WAVE_MODE_PUSH_PULL    3'h4
`define WAVE_MODE_BRIDGE_FWD   3'h2
`define WAVE_MODE_BRIDGE_REV   3'h3
`define WAVE_SRC_COUNT         14
`define WAVE_SRC_SEL_W         4
`define WAVE_DEAD_BAND_CYCLES  8
`define WAVE_DEAD_CNT_W        6
`define WAVE_RESET_MODE        3'h0
`define WAVE_RESET_SENSE       4'hf
`endif

// [include/wave_pkg.sv]
// types for the complementary waveform output stage
package wave_pkg;
	typedef enum logic [2:0] {
		BR_IDLE = 3'b001,
		BR_DEAD = 3'b010,
		BR_RUN  = 3'b100
	} bridge_state_type;
endpackage

// [core/wave_src_mux.sv]
// input source selector with constant low for unused codes
`timescale 1ns/100ps
`include "wave_map.svh"
module wave_src_mux
	import wave_pkg::*;
#(
	parameter int SRC_N = `WAVE_SRC_COUNT
) (
	input  wire logic [SRC_N-1:0]            src_in,
	input  wire logic [`WAVE_SRC_SEL_W-1:0]  sel_in,
	output logic                             src_out
);
	// codes past the list read low
	always_comb begin
		src_out = 1'b0;
		if (sel_in < SRC_N[`WAVE_SRC_SEL_W-1:0]) begin
			src_out = src_in[sel_in];
		end
	end
endmodule

// [core/wave_sync2.sv]
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/100ps
module wave_sync2
	import wave_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         ce_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else if (ce_in) begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule

// [bench/gate_drive_model.sv]
// pulse-counting model of the external gate drivers
`timescale 1ns/100ps
module gate_drive_model (
	input  wire logic gate_a_in,
	input  wire logic gate_b_in,
	output int        pulses_a_out,
	output int        pulses_b_out
);
	int count_a = 0;
	int count_b = 0;
	// each turn-on edge fires the switch once; bench uses deltas, so start-up x is harmless
	always @(posedge gate_a_in) count_a++;
	always @(posedge gate_b_in) count_b++;
	assign pulses_a_out = count_a;
	assign pulses_b_out = count_b;
endmodule

// [bench/tb_top.sv]
// self-checking bench for the waveform output stage
`timescale 1ns/100ps
`include "wave_map.svh"
module tb_top;
	logic        clk_sys_in = 1'b0;
	logic        clk_fast_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        clock_select_in = 1'b0;
	logic        enable_in = 1'b0;
	logic        ce = 1'b1;
	logic        shutdown_in = 1'b0;
	logic [2:0]  mode_in = 3'h0;
	logic [3:0]  sel = 4'h0;
	logic [3:0]  sense = 4'hf;
	logic [3:0]  steer = 4'h0;
	logic [3:0]  ov_en = 4'h0;
	logic [3:0]  ov_lvl = 4'h0;
	logic [13:0] src = 14'h0;
	logic [31:0] r;
	logic        wave_out_a;
	logic        wave_out_b;
	logic        wave_out_c;
	logic        wave_out_d;
	logic        clock_is_fast_out;
	int          pulses_a;
	int          pulses_b;
	int          pa;
	int          pb;
	int          fails = 0;
	int          comparisons = 0;
	int          seed;

	always #12.5 clk_sys_in = ~clk_sys_in;
	always #31.25 clk_fast_in = ~clk_fast_in;

	wave_stage #(.DEAD_BAND(4)) u_wave_stage (
		.clk_sys_in(clk_sys_in), .clk_fast_in(clk_fast_in), .rst_n_in(rst_n_in),
		.ce_in(ce), .clock_select_in(clock_select_in), .enable_in(enable_in),
		.mode_in(mode_in), .input_source_mux_select_in(sel), .src_in(src),
		.per_output_level_sense_in(sense), .steer_enable_in(steer),
		.shutdown_in(shutdown_in), .override_en_in(ov_en), .override_level_in(ov_lvl),
		.wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_out_c(wave_out_c),
		.wave_out_d(wave_out_d), .clock_is_fast_out(clock_is_fast_out));

	gate_drive_model u_gate_drive_model (
		.gate_a_in(wave_out_a), .gate_b_in(wave_out_b),
		.pulses_a_out(pulses_a), .pulses_b_out(pulses_b));

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask

	function automatic logic [3:0] sensed(input logic [3:0] act, input logic [3:0] pol);
		return ~(act ^ pol);
	endfunction

	function automatic logic pick(input logic [13:0] s, input logic [3:0] code);
		return (code < 4'he) ? s[code] : 1'b0;
	endfunction

	task automatic check_outs(input logic [3:0] exp);
		comparisons++;
		if ({wave_out_d, wave_out_c, wave_out_b, wave_out_a} !== exp) begin
			fails++;
			$display("wrong value at %0t: outputs %b expected %b", $time,
				{wave_out_d, wave_out_c, wave_out_b, wave_out_a}, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic check_num(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			fails++;
			$display("wrong value at %0t: pulse count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic do_reset(input logic fast);
		rst_n_in = 1'b0;
		clock_select_in = fast;
		cyc(16);
		rst_n_in = 1'b1;
		cyc(4);
	endtask

	task automatic drive_in(input logic v);
		src[0] = v;
		cyc(20);
	endtask

	// one input pulse, checked while high; c and d follow a and b
	task automatic pp_pulse(input logic on_a);
		drive_in(1'b1);
		check_outs(sensed(on_a ? 4'b0101 : 4'b1010, sense));
		drive_in(1'b0);
		check_outs(sensed(4'h0, sense));
	endtask

	task automatic finish_test();
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#200000;
		fails++;
		finish_test();
	end

	initial begin
		seed = 32'hbef8;
		do_reset(1'b0);
		enable_in = 1'b1;
		mode_in = `WAVE_MODE_ASYNC_STEER;
		// every source code first, then overrides mixed in
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			sel = (i < 16) ? i[3:0] : r[3:0];
			steer = r[7:4];
			sense = r[11:8];
			ov_en = (i >= 20) ? r[15:12] : 4'h0;
			ov_lvl = r[19:16];
			src = r[31:18];
			cyc(20);
			check_outs((ov_en & ov_lvl) | (~ov_en & sensed(steer & {4{pick(src, sel)}}, sense)));
		end
		ov_en = 4'h0;
		sel = 4'h0;
		sense = 4'hf;
		steer = 4'h0;
		drive_in(1'b1);
		steer = 4'ha;
		cyc(1);
		check_outs(4'ha);
		ce = 1'b0;
		steer = 4'h5;
		cyc(5);
		check_outs(4'ha);
		ce = 1'b1;
		cyc(1);
		check_outs(4'h5);
		mode_in = `WAVE_MODE_SYNC_STEER;
		drive_in(1'b0);
		steer = 4'hf;
		drive_in(1'b1);
		check_outs(4'hf);
		steer = 4'h1;
		cyc(20);
		check_outs(4'hf);
		drive_in(1'b0);
		drive_in(1'b1);
		check_outs(4'h1);
		mode_in = `WAVE_MODE_BRIDGE_FWD;
		cyc(20);
		check_outs(4'b1001);
		drive_in(1'b0);
		check_outs(4'b0001);
		src[0] = 1'b1;
		mode_in = `WAVE_MODE_BRIDGE_REV;
		cyc(3);
		check_outs(4'h0);
		cyc(20);
		check_outs(4'b0110);
		drive_in(1'b0);
		check_outs(4'b0100);
		mode_in = `WAVE_MODE_PUSH_PULL;
		sense = 4'b0011;
		cyc(20);
		pa = pulses_a;
		pb = pulses_b;
		for (int k = 0; k < 6; k++) begin
			pp_pulse(k % 2 == 0);
		end
		check_num(pulses_a - pa, 3);
		check_num(pulses_b - pb, 3);
		for (int j = 0; j < 2; j++) begin
			pp_pulse(j == 0);
			if (j == 0) enable_in = 1'b0;
			else shutdown_in = 1'b1;
			cyc(20);
			enable_in = 1'b1;
			shutdown_in = 1'b0;
			cyc(20);
			pp_pulse(1'b1);
		end
		mode_in = 3'h6;
		drive_in(1'b1);
		check_outs(sensed(4'h0, sense));
		mode_in = `WAVE_MODE_ASYNC_STEER;
		steer = 4'hf;
		shutdown_in = 1'b1;
		cyc(20);
		check_outs(sensed(4'h0, sense));
		shutdown_in = 1'b0;
		cyc(20);
		check_outs(sensed(4'hf, sense));
		do_reset(1'b1);
		mode_in = `WAVE_MODE_ASYNC_STEER;
		sense = 4'hf;
		steer = 4'hf;
		src[0] = 1'b1;
		cyc(40);
		check_bit(clock_is_fast_out, 1'b1);
		check_outs(4'hf);
		finish_test();
	end
endmodule
